/* core/plcw_pkg.sv */
package plcw_pkg;
   localparam logic [7:0] NVM_WORD_ADDR = 8'h1b;
   localparam logic [15:0] WORD_RESET = 16'h4503;
   localparam logic [15:0] RSVD_MASK = 16'h0048;
   localparam int unsigned B_DLY_LO = 0;
   localparam int unsigned B_IDLE_MASK = 2;
   localparam int unsigned B_SKIP_DIS = 4;
   localparam int unsigned B_L2_BLOCK = 5;
   localparam int unsigned B_MSIX_LO = 7;
   localparam int unsigned B_LB_DIS = 10;
   localparam int unsigned B_GOOD_REC = 11;
   localparam int unsigned B_LEGACY = 12;
   localparam int unsigned B_DNRST_DIS = 13;
   localparam int unsigned B_DLY_HI = 14;
   localparam int unsigned B_RX_FORCE = 15;
   localparam logic [3:0] OFF_WORD = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_LEVEL = 4'h8;
   localparam int unsigned ST_LOADED = 0;
   localparam int unsigned ST_BUSY = 1;
   localparam int unsigned ST_L1_REQ = 2;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned T_L1_4US = 4;
   localparam int unsigned T_L1_8US = 8;
   localparam int unsigned T_L1_16US = 16;
   localparam int unsigned T_L1_32US = 32;
   localparam int unsigned T_L1_64US = 64;
   localparam int unsigned T_L1_256US = 256;
   localparam int unsigned T_L1_1MS = 1;
   localparam int unsigned T_L1_4MS = 4;
   localparam int unsigned DLY_W = 24;
   localparam logic [7:0][DLY_W-1:0] L1_DELAY_CYC = {
      DLY_W'(T_L1_4MS * 1000 * CLK_MHZ), DLY_W'(T_L1_1MS * 1000 * CLK_MHZ),
      DLY_W'(T_L1_256US * CLK_MHZ), DLY_W'(T_L1_64US * CLK_MHZ),
      DLY_W'(T_L1_32US * CLK_MHZ), DLY_W'(T_L1_16US * CLK_MHZ),
      DLY_W'(T_L1_8US * CLK_MHZ), DLY_W'(T_L1_4US * CLK_MHZ)};
   localparam int unsigned LB_W = 4;
   localparam int unsigned LB_LEAK_NS = 5000;
   localparam int unsigned LB_LEAK_CYC = LB_LEAK_NS * CLK_MHZ / 1000;
   localparam logic [LB_W-1:0] LB_INC = 4'h4;
   localparam logic [LB_W-1:0] LB_THRESH = 4'hc;
   typedef enum logic [1:0] {
      LD_IDLE = 2'b00,
      LD_REQ = 2'b01,
      LD_DONE = 2'b10
   } plcw_ld_e;
   typedef struct packed {
      plcw_ld_e ld;
      logic [15:0] word;
      logic loaded;
      logic nvm_req;
      logic [31:0] rdata;
      logic rx_s1;
      logic rx_s2;
      logic rx_present;
      logic link_up_d;
      logic core_rst;
      logic eidle_entry;
      logic eidle_bad;
      logic skip_go;
      logic l2_go;
      logic [3:0] msix_size;
   } plcw_top_s;
endpackage : plcw_pkg

/* core/plcw_l1_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module plcw_l1_timer #(
   parameter int unsigned CNT_W = 24
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic idle,
   input wire logic [CNT_W-1:0] limit,
   output logic l1_req
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic req;
   } plcw_tmr_s;
   plcw_tmr_s st_ff;
   plcw_tmr_s nxt_st;

   // The count saturates at the limit, so a long L0s stay cannot wrap and drop the request.
   always_comb
   begin
      nxt_st = st_ff;
      if (!idle)
      begin
         nxt_st.cnt = '0;
         nxt_st.req = 1'b0;
      end
      else
      begin
         if (st_ff.cnt < limit)
         begin
            nxt_st.cnt = CNT_W'(st_ff.cnt + 1'b1);
         end
         nxt_st.req = (nxt_st.cnt >= limit);
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign l1_req = st_ff.req;
endmodule : plcw_l1_timer
`default_nettype wire

/* core/plcw_leaky.sv */
`timescale 1ns/1ps
`default_nettype none
module plcw_leaky #(
   parameter int unsigned LVL_W = plcw_pkg::LB_W,
   parameter int unsigned LEAK_CYC = plcw_pkg::LB_LEAK_CYC,
   parameter logic [LVL_W-1:0] INC = plcw_pkg::LB_INC,
   parameter logic [LVL_W-1:0] THRESH = plcw_pkg::LB_THRESH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic disable_bucket,
   input wire logic disp_err,
   output logic [LVL_W-1:0] level,
   output logic recov_req
);
   typedef struct packed {
      logic [LVL_W-1:0] lvl;
      logic [15:0] leak;
      logic recov;
   } plcw_lb_s;
   plcw_lb_s st_ff;
   plcw_lb_s nxt_st;
   logic [LVL_W:0] sum;

   always_comb
   begin
      nxt_st = st_ff;
      sum = '0;
      nxt_st.recov = 1'b0;
      if (disable_bucket)
      begin
         nxt_st = '0;
      end
      else
      begin
         if (st_ff.leak == 16'(LEAK_CYC - 1))
         begin
            nxt_st.leak = '0;
            if (st_ff.lvl != '0)
            begin
               nxt_st.lvl = LVL_W'(st_ff.lvl - 1'b1);
            end
         end
         else
         begin
            nxt_st.leak = 16'(st_ff.leak + 1'b1);
         end
         if (disp_err)
         begin
            sum = {1'b0, nxt_st.lvl} + {1'b0, INC};
            nxt_st.lvl = sum[LVL_W] ? '1 : sum[LVL_W-1:0];
         end
         // Emptying the bucket on a trip gives the link time to retrain before the next one.
         if (nxt_st.lvl >= THRESH)
         begin
            nxt_st.recov = 1'b1;
            nxt_st.lvl = '0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.lvl;
   assign recov_req = st_ff.recov;
endmodule : plcw_leaky
`default_nettype wire

/* core/plcw_top.sv */
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module plcw_top #(
   parameter logic [7:0][plcw_pkg::DLY_W-1:0] L1_DELAY_CYC = plcw_pkg::L1_DELAY_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   output logic NVM_RD_REQ,
   output logic [7:0] NVM_RD_ADDR,
   input wire logic NVM_RD_ACK,
   input wire logic [15:0] NVM_RD_DATA,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic DEFAULTS_LOADED,
   input wire logic L0S_IDLE,
   output logic [2:0] L1_ENTRY_DELAY,
   output logic L1_ENTRY_REQ,
   input wire logic EIDLE_OS_SEEN,
   input wire logic EIDLE_CM_SEEN,
   output logic EIDLE_ENTRY,
   output logic EIDLE_ILLEGAL,
   input wire logic SKIP_INS_REQ,
   output logic SKIP_INS_GO,
   input wire logic L2_ENTRY_REQ,
   output logic L2_ENTRY_GO,
   output logic [2:0] MSIX_VECTOR_COUNT,
   output logic [3:0] MSIX_TABLE_SIZE,
   input wire logic DISP_ERR,
   output logic RECOV_RETRAIN_REQ,
   output logic FORCE_GOOD_RECOV,
   output logic LINK_FSM_LEGACY_SELECT,
   input wire logic LINK_UP,
   output logic CORE_RST_REQ,
   input wire logic RX_DETECT_PIN,
   output logic RX_PRESENT
);
   plcw_pkg::plcw_top_s st_ff;
   plcw_pkg::plcw_top_s nxt_st;
   logic [2:0] dly_code;
   logic l1_req;
   logic recov_req;
   logic [plcw_pkg::LB_W-1:0] lb_level;

   assign dly_code = {st_ff.word[plcw_pkg::B_DLY_HI],
                      st_ff.word[plcw_pkg::B_DLY_LO+1:plcw_pkg::B_DLY_LO]};

   plcw_l1_timer #(
      .CNT_W(plcw_pkg::DLY_W)
   ) u_l1_timer (
      .clk(CLK),
      .rst_b(RST_B),
      .idle(L0S_IDLE),
      .limit(L1_DELAY_CYC[dly_code]),
      .l1_req(l1_req)
   );

   plcw_leaky u_leaky (
      .clk(CLK),
      .rst_b(RST_B),
      .disable_bucket(st_ff.word[plcw_pkg::B_LB_DIS]),
      .disp_err(DISP_ERR),
      .level(lb_level),
      .recov_req(recov_req)
   );

   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = '0;
      nxt_st.core_rst = 1'b0;
      case (st_ff.ld)
         plcw_pkg::LD_IDLE:
         begin
            nxt_st.ld = plcw_pkg::LD_REQ;
            nxt_st.nvm_req = 1'b1;
         end
         plcw_pkg::LD_REQ:
         begin
            if (NVM_RD_ACK)
            begin
               nxt_st.ld = plcw_pkg::LD_DONE;
               nxt_st.nvm_req = 1'b0;
               nxt_st.loaded = 1'b1;
            end
         end
         plcw_pkg::LD_DONE:
         begin
            nxt_st.nvm_req = 1'b0;
         end
         default:
         begin
            nxt_st.ld = plcw_pkg::LD_IDLE;
            nxt_st.nvm_req = 1'b0;
         end
      endcase
      // The memory word lands last, so a write racing the load loses to the stored default.
      if (REG_WR && REG_ADDR == plcw_pkg::OFF_WORD)
      begin
         nxt_st.word = REG_WDATA[15:0] & ~plcw_pkg::RSVD_MASK;
      end
      if (st_ff.ld == plcw_pkg::LD_REQ && NVM_RD_ACK)
      begin
         nxt_st.word = NVM_RD_DATA & ~plcw_pkg::RSVD_MASK;
      end
      if (REG_RD)
      begin
         case (REG_ADDR)
            plcw_pkg::OFF_WORD:
            begin
               nxt_st.rdata = {16'h0000, st_ff.word};
            end
            plcw_pkg::OFF_STATUS:
            begin
               nxt_st.rdata[plcw_pkg::ST_LOADED] = st_ff.loaded;
               nxt_st.rdata[plcw_pkg::ST_BUSY] = st_ff.nvm_req;
               nxt_st.rdata[plcw_pkg::ST_L1_REQ] = l1_req;
            end
            plcw_pkg::OFF_LEVEL:
            begin
               nxt_st.rdata[plcw_pkg::LB_W-1:0] = lb_level;
            end
            default:
            begin
               nxt_st.rdata = '0;
            end
         endcase
      end
      if (st_ff.word[plcw_pkg::B_IDLE_MASK])
      begin
         nxt_st.eidle_entry = EIDLE_OS_SEEN | EIDLE_CM_SEEN;
         nxt_st.eidle_bad = 1'b0;
      end
      else
      begin
         nxt_st.eidle_entry = EIDLE_OS_SEEN & EIDLE_CM_SEEN;
         nxt_st.eidle_bad = EIDLE_OS_SEEN ^ EIDLE_CM_SEEN;
      end
      nxt_st.skip_go = SKIP_INS_REQ & ~st_ff.word[plcw_pkg::B_SKIP_DIS];
      nxt_st.l2_go = L2_ENTRY_REQ & ~st_ff.word[plcw_pkg::B_L2_BLOCK];
      nxt_st.msix_size = {1'b0, st_ff.word[plcw_pkg::B_MSIX_LO+2:plcw_pkg::B_MSIX_LO]}
                         + 4'h1;
      nxt_st.link_up_d = LINK_UP;
      if (st_ff.link_up_d && !LINK_UP && !st_ff.word[plcw_pkg::B_DNRST_DIS])
      begin
         nxt_st.core_rst = 1'b1;
      end
      // The detect pin is asynchronous, so only the second stage is looked at.
      nxt_st.rx_s1 = RX_DETECT_PIN;
      nxt_st.rx_s2 = st_ff.rx_s1;
      nxt_st.rx_present = st_ff.rx_s2 | st_ff.word[plcw_pkg::B_RX_FORCE];
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         st_ff <= '0;
         st_ff.ld <= plcw_pkg::LD_IDLE;
         st_ff.word <= plcw_pkg::WORD_RESET;
         st_ff.msix_size <= 4'h3;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign NVM_RD_REQ = st_ff.nvm_req;
   assign NVM_RD_ADDR = plcw_pkg::NVM_WORD_ADDR;
   assign REG_RDATA = st_ff.rdata;
   assign DEFAULTS_LOADED = st_ff.loaded;
   assign L1_ENTRY_DELAY = dly_code;
   assign L1_ENTRY_REQ = l1_req;
   assign EIDLE_ENTRY = st_ff.eidle_entry;
   assign EIDLE_ILLEGAL = st_ff.eidle_bad;
   assign SKIP_INS_GO = st_ff.skip_go;
   assign L2_ENTRY_GO = st_ff.l2_go;
   assign MSIX_VECTOR_COUNT = st_ff.word[plcw_pkg::B_MSIX_LO+2:plcw_pkg::B_MSIX_LO];
   assign MSIX_TABLE_SIZE = st_ff.msix_size;
   assign RECOV_RETRAIN_REQ = recov_req;
   assign FORCE_GOOD_RECOV = st_ff.word[plcw_pkg::B_GOOD_REC];
   assign LINK_FSM_LEGACY_SELECT = st_ff.word[plcw_pkg::B_LEGACY];
   assign CORE_RST_REQ = st_ff.core_rst;
   assign RX_PRESENT = st_ff.rx_present;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   chk_nvm_addr_fixed: assert property (NVM_RD_REQ |-> NVM_RD_ADDR == 8'h1b)
      else $error("memory request not aimed at the control word");
   chk_load_apply: assert property (NVM_RD_REQ && NVM_RD_ACK |=>
      st_ff.word == ($past(NVM_RD_DATA) & 16'hffb7) && DEFAULTS_LOADED && !NVM_RD_REQ)
      else $error("loaded word not applied");
   chk_l1_delay_code: assert property (L1_ENTRY_DELAY ==
      {st_ff.word[14], st_ff.word[1:0]})
      else $error("delay code not built from bits 14 and 1:0");
   chk_l1_after_idle: assert property (L1_ENTRY_REQ |-> $past(L0S_IDLE) && L0S_IDLE
      || $past(L0S_IDLE))
      else $error("L1 request without L0s idle");
   chk_eidle_mask: assert property (EIDLE_OS_SEEN && !EIDLE_CM_SEEN |=>
      EIDLE_ENTRY == $past(st_ff.word[2]) && EIDLE_ILLEGAL == !$past(st_ff.word[2]))
      else $error("idle mask not honoured");
   chk_skip_gate: assert property (SKIP_INS_REQ && st_ff.word[4] |=> !SKIP_INS_GO)
      else $error("skip inserted while disabled");
   chk_l2_block: assert property (L2_ENTRY_REQ |=> L2_ENTRY_GO == !$past(st_ff.word[5]))
      else $error("L2 gate wrong");
   chk_msix_size: assert property (1'b1 |=>
      MSIX_TABLE_SIZE == {1'b0, $past(st_ff.word[9:7])} + 4'h1)
      else $error("table size not count plus one");
   chk_lb_off: assert property (st_ff.word[10] |=> !RECOV_RETRAIN_REQ)
      else $error("retrain requested with bucket off");
   chk_core_reset: assert property ($fell(LINK_UP) |=>
      CORE_RST_REQ == !$past(st_ff.word[13]))
      else $error("core reset on link loss wrong");
   chk_rx_force: assert property (st_ff.word[15] |=> RX_PRESENT)
      else $error("presence override ignored");
endmodule : plcw_top
`default_nettype wire

/* verif/plcw_nvm_model.sv */
`timescale 1ns/1ps
`default_nettype none
module plcw_nvm_model #(
   parameter int unsigned DELAY = 6,
   parameter logic [15:0] IMAGE = 16'hffff
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic rd_req,
   input wire logic [7:0] rd_addr,
   output logic rd_ack = 1'b0,
   output logic [15:0] rd_data = 16'h0000
);
   int unsigned wait_n = 0;
   // Data toggles outside the ack cycle, so a late or early sample is caught.
   always @(posedge clk)
   begin
      if (rst_b && rd_req && !rd_ack && wait_n == DELAY)
      begin
         wait_n <= 0;
         rd_ack <= 1'b1;
         rd_data <= (rd_addr == plcw_pkg::NVM_WORD_ADDR) ? IMAGE : 16'h0000;
      end
      else
      begin
         rd_ack <= 1'b0;
         rd_data <= ~rd_data;
         if (!rst_b)
            wait_n <= 0;
         else if (rd_req && !rd_ack)
            wait_n <= wait_n + 1;
      end
   end
endmodule : plcw_nvm_model
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic nvm_req, nvm_ack, loaded, l1_req, eentry, eill, skip_go, l2_go;
   logic recov, good_rec, legacy, core_rst, rx_present;
   logic [7:0] nvm_addr;
   logic [15:0] nvm_data;
   logic [31:0] rdata;
   logic [2:0] l1_dly, msix_cnt;
   logic [3:0] msix_size;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h00000000;
   logic wr = 1'b0, rd = 1'b0, idle = 1'b0, eos = 1'b0, ecm = 1'b0;
   logic skip_req = 1'b0, l2_req = 1'b0, disp = 1'b0, link_up = 1'b1, rx_pin = 1'b0;
   int errors = 0;
   int compares = 0;
   int recov_n = 0;
   int rst_n = 0;

   always #2.5 clk = ~clk;

   plcw_top #(
      .L1_DELAY_CYC({24'h50, 24'h46, 24'h3c, 24'h32, 24'h28, 24'h1e, 24'h14, 24'h0a})
   ) u_dut (
      .CLK(clk), .RST_B(rst_b), .NVM_RD_REQ(nvm_req), .NVM_RD_ADDR(nvm_addr),
      .NVM_RD_ACK(nvm_ack), .NVM_RD_DATA(nvm_data), .REG_ADDR(addr),
      .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .DEFAULTS_LOADED(loaded), .L0S_IDLE(idle), .L1_ENTRY_DELAY(l1_dly),
      .L1_ENTRY_REQ(l1_req), .EIDLE_OS_SEEN(eos), .EIDLE_CM_SEEN(ecm),
      .EIDLE_ENTRY(eentry), .EIDLE_ILLEGAL(eill), .SKIP_INS_REQ(skip_req),
      .SKIP_INS_GO(skip_go), .L2_ENTRY_REQ(l2_req), .L2_ENTRY_GO(l2_go),
      .MSIX_VECTOR_COUNT(msix_cnt), .MSIX_TABLE_SIZE(msix_size), .DISP_ERR(disp),
      .RECOV_RETRAIN_REQ(recov), .FORCE_GOOD_RECOV(good_rec),
      .LINK_FSM_LEGACY_SELECT(legacy), .LINK_UP(link_up), .CORE_RST_REQ(core_rst),
      .RX_DETECT_PIN(rx_pin), .RX_PRESENT(rx_present)
   );

   plcw_nvm_model u_nvm (
      .clk(clk), .rst_b(rst_b), .rd_req(nvm_req), .rd_addr(nvm_addr),
      .rd_ack(nvm_ack), .rd_data(nvm_data)
   );

   // Pulse counters also catch a pulse that sticks high for more than one cycle.
   always @(posedge clk)
   begin
      if (recov === 1'b1)
         recov_n++;
      if (core_rst === 1'b1)
         rst_n++;
   end

   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : bus_rd

   task automatic setw(input logic [15:0] w);
      bus_wr(plcw_pkg::OFF_WORD, {16'hffff, w});
      cyc(3);
   endtask : setw

   task automatic pulses;
      repeat (3)
      begin
         @(posedge clk);
         disp <= 1'b1;
         @(posedge clk);
         disp <= 1'b0;
      end
      cyc(10);
   endtask : pulses

   initial
   begin
      logic [31:0] d;
      logic [15:0] w;
      int n;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      cyc(1);
      chk("nvm_addr", 32'h1b, 32'(nvm_addr));
      chk("nvm_req", 32'h1, 32'(nvm_req));
      chk("l1_dly", 32'h7, 32'(l1_dly));
      chk("msix_size", 32'h3, 32'(msix_size));
      bus_rd(plcw_pkg::OFF_WORD, d);
      chk("word", 32'h4503, d);
      n = 0;
      while (loaded !== 1'b1 && n < 50)
      begin
         cyc(1);
         n++;
      end
      if (loaded !== 1'b1)
      begin
         errors++;
         wrap_up();
      end
      chk("loaded", 32'h1, 32'(loaded));
      chk("nvm_req", 32'h0, 32'(nvm_req));
      bus_rd(plcw_pkg::OFF_WORD, d);
      chk("word", 32'hffb7, d);
      cyc(1);
      chk("rdata_idle", 32'h0, rdata);
      bus_wr(plcw_pkg::OFF_STATUS, 32'hffffffff);
      bus_rd(plcw_pkg::OFF_STATUS, d);
      chk("status", 32'h1, d);
      bus_rd(4'hc, d);
      chk("unmapped", 32'h0, d);
      $display("test load done");
      for (int c = 0; c < 8; c++)
      begin
         setw({1'b0, c[2], 12'h000, c[1:0]});
         chk("l1_dly", 32'(c), 32'(l1_dly));
         @(posedge clk);
         idle <= 1'b1;
         cyc(10 * (c + 1) - 2);
         chk("l1_early", 32'h0, 32'(l1_req));
         cyc(4);
         chk("l1_req", 32'h1, 32'(l1_req));
         bus_rd(plcw_pkg::OFF_STATUS, d);
         chk("status_l1", 32'h5, d);
         @(posedge clk);
         idle <= 1'b0;
         cyc(2);
         chk("l1_drop", 32'h0, 32'(l1_req));
      end
      $display("test l1 done");
      @(posedge clk);
      eos <= 1'b1;
      skip_req <= 1'b1;
      l2_req <= 1'b1;
      for (int m = 0; m < 8; m++)
      begin
         w = {3'b000, m[1], m[0], 1'b1, m[2:0], m[2], m[2], m[1], m[2], m[0], 2'b00};
         setw(w);
         chk("eentry", 32'(m[0]), 32'(eentry));
         chk("eill", 32'(!m[0]), 32'(eill));
         chk("skip_go", 32'(!m[1]), 32'(skip_go));
         chk("l2_go", 32'(!m[2]), 32'(l2_go));
         chk("msix_cnt", 32'(m), 32'(msix_cnt));
         chk("msix_size", 32'(m + 1), 32'(msix_size));
         chk("good_rec", 32'(m[0]), 32'(good_rec));
         chk("legacy", 32'(m[1]), 32'(legacy));
         bus_rd(plcw_pkg::OFF_WORD, d);
         chk("word", {16'h0000, w & 16'hffb7}, d);
      end
      @(posedge clk);
      ecm <= 1'b1;
      setw(16'h0000);
      chk("eentry", 32'h1, 32'(eentry));
      chk("eill", 32'h0, 32'(eill));
      @(posedge clk);
      eos <= 1'b0;
      setw(16'h0004);
      chk("eentry", 32'h1, 32'(eentry));
      chk("eill", 32'h0, 32'(eill));
      $display("test decode done");
      setw(16'h0000);
      pulses();
      chk("recov_n", 32'h1, 32'(recov_n));
      @(posedge clk);
      disp <= 1'b1;
      @(posedge clk);
      disp <= 1'b0;
      bus_rd(plcw_pkg::OFF_LEVEL, d);
      chk("level", 32'h4, d);
      setw(16'h0400);
      pulses();
      chk("recov_n", 32'h1, 32'(recov_n));
      $display("test bucket done");
      setw(16'h0000);
      @(posedge clk);
      link_up <= 1'b0;
      cyc(5);
      chk("rst_n", 32'h1, 32'(rst_n));
      @(posedge clk);
      link_up <= 1'b1;
      setw(16'h2000);
      @(posedge clk);
      link_up <= 1'b0;
      cyc(5);
      chk("rst_n", 32'h1, 32'(rst_n));
      $display("test link down done");
      setw(16'h8000);
      chk("rx_present", 32'h1, 32'(rx_present));
      setw(16'h0000);
      chk("rx_present", 32'h0, 32'(rx_present));
      @(posedge clk);
      rx_pin <= 1'b1;
      cyc(4);
      chk("rx_present", 32'h1, 32'(rx_present));
      $display("test presence done");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
